// >>> hdl/ifsw_pkg.sv
/*
  package for the interrupt flag and sleep/wake block: register map,
  bit positions, reset values, sleep states.
  assumes a 32-bit axi4-lite slave with byte addresses = index * 4.
*/
package ifsw_pkg;
  // register indices and byte addresses
  localparam logic [11:0] IFSW_IDX_FLAG0 = 12'h70c;
  localparam logic [11:0] IFSW_IDX_FLAG1 = 12'h70d;
  localparam logic [11:0] IFSW_IDX_FLAG2 = 12'h70e;
  localparam logic [11:0] IFSW_IDX_EN0 = 12'h716;
  localparam logic [11:0] IFSW_IDX_EN1 = 12'h717;
  localparam logic [11:0] IFSW_IDX_EN2 = 12'h718;
  localparam logic [11:0] IFSW_IDX_CTRL = 12'h720;
  localparam logic [11:0] IFSW_IDX_STAT = 12'h721;
  localparam logic [13:0] IFSW_ADDR_FLAG0 = {IFSW_IDX_FLAG0, 2'b00};
  localparam logic [13:0] IFSW_ADDR_FLAG1 = {IFSW_IDX_FLAG1, 2'b00};
  localparam logic [13:0] IFSW_ADDR_FLAG2 = {IFSW_IDX_FLAG2, 2'b00};
  localparam logic [13:0] IFSW_ADDR_EN0 = {IFSW_IDX_EN0, 2'b00};
  localparam logic [13:0] IFSW_ADDR_EN1 = {IFSW_IDX_EN1, 2'b00};
  localparam logic [13:0] IFSW_ADDR_EN2 = {IFSW_IDX_EN2, 2'b00};
  localparam logic [13:0] IFSW_ADDR_CTRL = {IFSW_IDX_CTRL, 2'b00};
  localparam logic [13:0] IFSW_ADDR_STAT = {IFSW_IDX_STAT, 2'b00};
  // bit positions
  localparam int IFSW_B_EXT = 0;
  localparam int IFSW_B_PINCHG = 4;
  localparam int IFSW_B_TMR0 = 5;
  localparam int IFSW_B_CONV = 0;
  localparam int IFSW_B_SSP = 1;
  localparam int IFSW_B_BCOL = 2;
  localparam int IFSW_B_TXRDY = 3;
  localparam int IFSW_B_RXPEND = 4;
  localparam int IFSW_B_TMR1 = 5;
  localparam int IFSW_B_TMR2 = 6;
  localparam int IFSW_B_CCP1 = 7;
  localparam int IFSW_B_GATE = 5;
  localparam int IFSW_B_NVM = 6;
  localparam int IFSW_B_CAPCMP_UNIT_TWO = 7;
  // control register bits
  localparam int IFSW_C_GIE = 0;
  localparam int IFSW_C_PERIPHERAL_IRQ_MASTER_ENABLE = 1;
  // implemented bits per register
  localparam logic [7:0] IFSW_MASK0 = 8'h31;
  localparam logic [7:0] IFSW_MASK1 = 8'hff;
  localparam logic [7:0] IFSW_MASK2 = 8'he0;
  // software-writable flag bits (hardware-only bits excluded)
  localparam logic [7:0] IFSW_WMASK0 = 8'h21;
  localparam logic [7:0] IFSW_WMASK1 = 8'he7;
  localparam logic [7:0] IFSW_WMASK2 = 8'he0;
  localparam logic [7:0] IFSW_RST_BYTE = 8'h00;
  localparam logic [1:0] IFSW_RESP_OKAY = 2'b00;
  localparam logic [1:0] IFSW_RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    IFSW_AWAKE = 3'b001,
    IFSW_ASLEEP = 3'b010,
    IFSW_WAKING = 3'b100
  } ifsw_state_t;
endpackage : ifsw_pkg

// >>> hdl/ifsw_top.sv
/*
  interrupt flag registers, enables and sleep/wake control.
  assumes an axi4-lite master, one clock, synchronous active-high reset;
  peripheral events are one-cycle pulses, levels are synchronous.
*/
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
module ifsw_top
  import ifsw_pkg::*;
(
  input wire logic clk, // 200 mhz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [13:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [13:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic rx_buf_nonempty, // receive buffer holds a byte
  input wire logic tx_buf_empty, // transmit holding buffer empty
  input wire logic pin_change_any, // or of pin change flags
  input wire logic ev_ext, // external interrupt edge
  input wire logic ev_tmr0, // timer zero overflow
  input wire logic ev_conv, // conversion complete
  input wire logic ev_ssp, // sync serial event
  input wire logic ev_bcol, // bus collision
  input wire logic ev_tmr1, // timer one overflow
  input wire logic ev_tmr2, // timer two match
  input wire logic ev_ccp1, // capcmp one event
  input wire logic ev_capcmp_unit_two, // capcmp two capture/match/trailing
  input wire logic ev_nvm, // nonvolatile op done
  input wire logic ev_gate, // timer one gate went inactive
  input wire logic sleep_exec, // core executes sleep instruction
  input wire logic wdt_timeout, // watchdog time-out
  input wire logic wdt_sleep_en, // watchdog enabled during sleep
  input wire logic conv_rc_clock, // converter clocked by its rc osc
  input wire logic osc_request, // peripheral requests an oscillator
  input wire logic [2:0] osc_force_on, // high/mid/low force-enable bits
  input wire logic [7:0] port_periph_active, // peripheral active per port
  output logic periph_irq, // peripheral interrupt request
  output logic irq_pending, // any enabled request pending
  output logic cpu_clk_en, // cpu and system clock enable
  output logic osc_keep_on, // keep internal oscillators running
  output logic wdt_clear, // watchdog and prescaler clear pulse
  output logic wdt_run, // watchdog counting
  output logic conv_abort, // abort conversion, power converter down
  output logic [7:0] port_hold, // latch port state per port
  output logic wake_resume, // resume at prefetched instruction
  output logic wake_vector, // call service routine after it
  output logic powerdown_status_n, // cleared by sleep entry
  output logic timeout_status_n // set by sleep entry
);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [13:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
    logic [7:0] flag0;
    logic [7:0] flag1;
    logic [7:0] flag2;
    logic [7:0] en0;
    logic [7:0] en1;
    logic [7:0] en2;
    logic global_irq_enable;
    logic peripheral_irq_master_enable;
    ifsw_state_t state;
    logic periph_irq;
    logic irq_pending;
    logic cpu_clk_en;
    logic osc_keep_on;
    logic wdt_clear;
    logic wdt_run;
    logic conv_abort;
    logic [7:0] port_hold;
    logic wake_resume;
    logic wake_vector;
    logic pd_n;
    logic to_n;
  } ifsw_regs_t;

  ifsw_regs_t st_ff;
  ifsw_regs_t nxt_st;

  // merge a written byte into sticky flags; a set event wins over a clear
  function automatic logic [7:0] ifsw_flag_upd(input logic [7:0] cur,
      input logic [7:0] ev, input logic wr, input logic [7:0] wd,
      input logic [7:0] wmask);
    logic [7:0] v;
    v = cur;
    if (wr) begin
      v = (cur & ~wmask) | (wd & wmask);
    end
    ifsw_flag_upd = v | ev;
  endfunction : ifsw_flag_upd

  logic [7:0] ev0;
  logic [7:0] ev1;
  logic [7:0] ev2;
  logic [7:0] live0;
  logic [7:0] live1;
  logic [7:0] live2;
  logic periph_req;
  logic wake_req;
  logic wr_go;
  logic rd_go;
  logic wr_lane;

  // event vectors and live flag views
  always_comb begin
    ev0 = 8'h00;
    ev1 = 8'h00;
    ev2 = 8'h00;
    ev0[IFSW_B_EXT] = ev_ext;
    ev0[IFSW_B_TMR0] = ev_tmr0;
    ev1[IFSW_B_BCOL] = ev_bcol;
    ev1[IFSW_B_SSP] = ev_ssp;
    ev1[IFSW_B_CONV] = ev_conv;
    ev1[IFSW_B_TMR1] = ev_tmr1;
    ev1[IFSW_B_TMR2] = ev_tmr2;
    ev1[IFSW_B_CCP1] = ev_ccp1;
    ev2[IFSW_B_CAPCMP_UNIT_TWO] = ev_capcmp_unit_two;
    ev2[IFSW_B_NVM] = ev_nvm;
    ev2[IFSW_B_GATE] = ev_gate;
    live0 = st_ff.flag0;
    live1 = st_ff.flag1;
    live2 = st_ff.flag2;
  end

  // request when a flag meets its enable
  // peripheral registers gated by master enable
  assign periph_req = (st_ff.peripheral_irq_master_enable &&
      (|(live1 & st_ff.en1) || |(live2 & st_ff.en2)));
  assign wake_req = |(live0 & st_ff.en0) || periph_req;

  assign wr_go = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  assign rd_go = s_axi_arvalid && !st_ff.rvalid;
  assign wr_lane = st_ff.wstrb[0];

  // next-state logic: bus, flags, sleep control
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wdt_clear = 1'b0;
    nxt_st.conv_abort = 1'b0;
    nxt_st.wake_resume = 1'b0;
    nxt_st.wake_vector = 1'b0;
    // write address and data captured independently
    if (s_axi_awvalid && !st_ff.aw_got) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_got) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // events set flags whatever the enables
    nxt_st.flag0 = ifsw_flag_upd(st_ff.flag0, ev0, 1'b0, 8'h00, 8'h00);
    nxt_st.flag1 = ifsw_flag_upd(st_ff.flag1, ev1, 1'b0, 8'h00, 8'h00);
    nxt_st.flag2 = ifsw_flag_upd(st_ff.flag2, ev2, 1'b0, 8'h00, 8'h00);
    if (wr_go) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = IFSW_RESP_OKAY;
      if (st_ff.awaddr == IFSW_ADDR_FLAG0) begin
        nxt_st.flag0 = ifsw_flag_upd(st_ff.flag0, ev0, wr_lane,
            st_ff.wdata[7:0], IFSW_WMASK0);
      end else if (st_ff.awaddr == IFSW_ADDR_FLAG1) begin
        // rx and tx bits excluded from writes
        nxt_st.flag1 = ifsw_flag_upd(st_ff.flag1, ev1, wr_lane,
            st_ff.wdata[7:0], IFSW_WMASK1);
      end else if (st_ff.awaddr == IFSW_ADDR_FLAG2) begin
        nxt_st.flag2 = ifsw_flag_upd(st_ff.flag2, ev2, wr_lane,
            st_ff.wdata[7:0], IFSW_WMASK2);
      end else if (st_ff.awaddr == IFSW_ADDR_EN0) begin
        if (wr_lane) nxt_st.en0 = st_ff.wdata[7:0] & IFSW_MASK0;
      end else if (st_ff.awaddr == IFSW_ADDR_EN1) begin
        if (wr_lane) nxt_st.en1 = st_ff.wdata[7:0] & IFSW_MASK1;
      end else if (st_ff.awaddr == IFSW_ADDR_EN2) begin
        if (wr_lane) nxt_st.en2 = st_ff.wdata[7:0] & IFSW_MASK2;
      end else if (st_ff.awaddr == IFSW_ADDR_CTRL) begin
        if (wr_lane) begin
          nxt_st.global_irq_enable = st_ff.wdata[IFSW_C_GIE];
          nxt_st.peripheral_irq_master_enable = st_ff.wdata[IFSW_C_PERIPHERAL_IRQ_MASTER_ENABLE];
        end
      end else if (st_ff.awaddr != IFSW_ADDR_STAT) begin
        nxt_st.bresp = IFSW_RESP_SLVERR;
      end
    end
    nxt_st.flag1[IFSW_B_RXPEND] = rx_buf_nonempty;
    // tx ready mirrors empty holding buffer
    nxt_st.flag1[IFSW_B_TXRDY] = tx_buf_empty;
    nxt_st.flag0[IFSW_B_PINCHG] = pin_change_any;
    // read decode
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = IFSW_RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      if (s_axi_araddr == IFSW_ADDR_FLAG0) begin
        nxt_st.rdata[7:0] = st_ff.flag0;
      end else if (s_axi_araddr == IFSW_ADDR_FLAG1) begin
        nxt_st.rdata[7:0] = st_ff.flag1;
      end else if (s_axi_araddr == IFSW_ADDR_FLAG2) begin
        nxt_st.rdata[7:0] = st_ff.flag2;
      end else if (s_axi_araddr == IFSW_ADDR_EN0) begin
        nxt_st.rdata[7:0] = st_ff.en0;
      end else if (s_axi_araddr == IFSW_ADDR_EN1) begin
        nxt_st.rdata[7:0] = st_ff.en1;
      end else if (s_axi_araddr == IFSW_ADDR_EN2) begin
        nxt_st.rdata[7:0] = st_ff.en2;
      end else if (s_axi_araddr == IFSW_ADDR_CTRL) begin
        nxt_st.rdata[IFSW_C_GIE] = st_ff.global_irq_enable;
        nxt_st.rdata[IFSW_C_PERIPHERAL_IRQ_MASTER_ENABLE] = st_ff.peripheral_irq_master_enable;
      end else if (s_axi_araddr == IFSW_ADDR_STAT) begin
        nxt_st.rdata[2:0] = {st_ff.state == IFSW_ASLEEP, st_ff.to_n,
            st_ff.pd_n};
      end else begin
        nxt_st.rresp = IFSW_RESP_SLVERR;
      end
    end
    // ready outputs registered from the next capture state
    nxt_st.awready = !nxt_st.aw_got;
    nxt_st.wready = !nxt_st.w_got;
    nxt_st.arready = !nxt_st.rvalid;
    nxt_st.periph_irq = periph_req;
    nxt_st.irq_pending = wake_req;
    // sleep state machine
    case (st_ff.state)
      IFSW_AWAKE: begin
        if (sleep_exec) begin
          if (wake_req && !st_ff.global_irq_enable) begin
            nxt_st.state = IFSW_AWAKE;
          end else begin
            nxt_st.state = IFSW_ASLEEP;
            nxt_st.pd_n = 1'b0;
            nxt_st.to_n = 1'b1;
            nxt_st.cpu_clk_en = 1'b0;
            nxt_st.wdt_clear = 1'b1;
            nxt_st.wdt_run = wdt_sleep_en;
            nxt_st.conv_abort = !conv_rc_clock;
            nxt_st.port_hold = ~port_periph_active;
          end
        end
      end
      IFSW_ASLEEP: begin
        nxt_st.osc_keep_on = osc_request || |osc_force_on;
        nxt_st.port_hold = ~port_periph_active;
        if (wake_req || wdt_timeout) begin
          nxt_st.state = IFSW_WAKING;
          nxt_st.wdt_clear = 1'b1;
          if (wdt_timeout && !wake_req) begin
            nxt_st.to_n = 1'b0;
          end
        end
      end
      IFSW_WAKING: begin
        nxt_st.state = IFSW_AWAKE;
        nxt_st.cpu_clk_en = 1'b1;
        nxt_st.osc_keep_on = 1'b0;
        nxt_st.port_hold = 8'h00;
        nxt_st.wdt_run = 1'b1;
        nxt_st.wake_resume = 1'b1;
        nxt_st.wake_vector = st_ff.global_irq_enable;
      end
      default: begin
        nxt_st.state = IFSW_AWAKE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.state <= IFSW_AWAKE;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.cpu_clk_en <= 1'b1;
      st_ff.wdt_run <= 1'b1;
      st_ff.pd_n <= 1'b1;
      st_ff.to_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign periph_irq = st_ff.periph_irq;
  assign irq_pending = st_ff.irq_pending;
  assign cpu_clk_en = st_ff.cpu_clk_en;
  assign osc_keep_on = st_ff.osc_keep_on;
  assign wdt_clear = st_ff.wdt_clear;
  assign wdt_run = st_ff.wdt_run;
  assign conv_abort = st_ff.conv_abort;
  assign port_hold = st_ff.port_hold;
  assign wake_resume = st_ff.wake_resume;
  assign wake_vector = st_ff.wake_vector;
  assign powerdown_status_n = st_ff.pd_n;
  assign timeout_status_n = st_ff.to_n;

  a_rx_flag_track: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> st_ff.flag1[IFSW_B_RXPEND] ==
      $past(rx_buf_nonempty)) else $error("rx flag lost buffer level");
  a_tx_flag_track: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 st_ff.flag1[IFSW_B_TXRDY] == $past(tx_buf_empty))
      else $error("tx flag lost buffer level");
  a_bcol_set: assert property (@(posedge clk) disable iff (sys_rst)
      ev_bcol |=> st_ff.flag1[IFSW_B_BCOL])
      else $error("collision flag not set");
  a_nvm_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      st_ff.flag2[IFSW_B_NVM] && !wr_go |=> st_ff.flag2[IFSW_B_NVM])
      else $error("memory flag dropped");
  // sleep with pending irq and global enable clear is no-op
  a_sleep_noop: assert property (@(posedge clk) disable iff (sys_rst)
      st_ff.state == IFSW_AWAKE && sleep_exec && wake_req && !st_ff.global_irq_enable
      |=> st_ff.state == IFSW_AWAKE && $stable(powerdown_status_n))
      else $error("sleep not a no-op");
  a_sleep_entry: assert property (@(posedge clk) disable iff (sys_rst)
      st_ff.state == IFSW_AWAKE && sleep_exec && !wake_req
      |=> !powerdown_status_n && timeout_status_n && !cpu_clk_en)
      else $error("sleep entry wrong");
  sequence s_wake_seen;
    st_ff.state == IFSW_ASLEEP && wake_req;
  endsequence
  a_wake_seq: assert property (@(posedge clk) disable iff (sys_rst)
      s_wake_seen |=> wdt_clear ##1 wake_resume && cpu_clk_en)
      else $error("wake sequence wrong");
  a_periph_req: assert property (@(posedge clk) disable iff (sys_rst)
      periph_req |=> periph_irq) else $error("request missing");
  a_peripheral_irq_master_enable_gate: assert property (@(posedge clk) disable iff (sys_rst)
      !st_ff.peripheral_irq_master_enable |=> !periph_irq) else $error("request without master");

endmodule : ifsw_top

// >>> sim/ifsw_cpu_model.sv
/*
  firmware side of the flag block: an axi4-lite master with tasks.
  assumes tb calls wr and rd one at a time on the system clock.
*/
`timescale 1ns/10ps
module ifsw_cpu_model (
  input wire logic clk, // system clock
  output logic [13:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // write strobes
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // response valid
  output logic s_axi_bready, // response ready
  output logic [13:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready // read data ready
);
  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end

  // firmware clears flags by writing zero
  task wr(input logic [13:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      @(posedge clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid & ~ah) | (s_axi_wvalid & ~wh));
    do begin
      @(negedge clk);
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
    end while (!bh);
    s_axi_bready <= 1'b0;
  endtask : wr

  // read one word; data and response taken mid-cycle while rvalid is high
  task rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      hit = s_axi_arready;
      @(posedge clk);
    end while (!hit);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
      hit = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
    end while (!hit);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : ifsw_cpu_model

// >>> sim/tb.sv
/*
  self-checking bench for the flag and sleep/wake block.
  assumes the cpu model as bus master and pulse events from the bench.
*/
`timescale 1ns/10ps
module tb;
  import ifsw_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [12:0] ev = '0; // events, sleep bit 11, watchdog bit 12
  logic rx_ne = 1'b0;
  logic tx_emp = 1'b0;
  logic [2:0] force_on = 3'b000;
  logic rc_clk = 1'b0; // converter on its rc clock
  logic wdt_slp = 1'b1; // watchdog runs in sleep
  logic [7:0] pact = 8'h0f; // ports with an active peripheral
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, periph_irq, irq_pending, cpu_clk_en;
  logic osc_keep_on, wdt_clear, wdt_run, conv_abort, wake_resume;
  logic wake_vector, powerdown_status_n, timeout_status_n;
  logic [7:0] port_hold;
  int bad_count = 0, checks_done = 0, cyc = 0;
  int n_clr = 0, n_abort = 0, n_res = 0, n_vec = 0;

  always #2.5 clk = ~clk;

  ifsw_top u_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_buf_nonempty(rx_ne),
    .tx_buf_empty(tx_emp), .pin_change_any(1'b0), .ev_ext(ev[0]),
    .ev_tmr0(ev[1]), .ev_conv(ev[2]), .ev_ssp(ev[3]), .ev_bcol(ev[4]),
    .ev_tmr1(ev[5]), .ev_tmr2(ev[6]), .ev_ccp1(ev[7]), .ev_capcmp_unit_two(ev[8]),
    .ev_nvm(ev[9]), .ev_gate(ev[10]), .sleep_exec(ev[11]),
    .wdt_timeout(ev[12]), .wdt_sleep_en(wdt_slp), .conv_rc_clock(rc_clk),
    .osc_request(1'b0), .osc_force_on(force_on),
    .port_periph_active(pact), .periph_irq, .irq_pending, .cpu_clk_en,
    .osc_keep_on, .wdt_clear, .wdt_run, .conv_abort, .port_hold,
    .wake_resume, .wake_vector, .powerdown_status_n, .timeout_status_n);

  ifsw_cpu_model u_cpu (.clk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // count output pulses mid-cycle; cut a hang short
  always @(negedge clk) begin
    cyc++;
    if (!sys_rst && wdt_clear === 1'b1) n_clr++;
    if (!sys_rst && conv_abort === 1'b1) n_abort++;
    if (!sys_rst && wake_resume === 1'b1) n_res++;
    if (!sys_rst && wake_vector === 1'b1) n_vec++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task rchk(input string nm, input logic [13:0] a, input logic [31:0] exp);
    u_cpu.rd(a, rv, resp);
    chk(nm, rv, exp);
  endtask : rchk

  task wr(input logic [13:0] a, input logic [7:0] d);
    u_cpu.wr(a, d, resp);
  endtask : wr

  task pulse(input logic [12:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
  endtask : pulse

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task finish_test();
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // register map, enable positions, unmapped refusal
  task t_regs();
    rchk("flag0", IFSW_ADDR_FLAG0, 0);
    rchk("flag2", IFSW_ADDR_FLAG2, 0);
    wr(IFSW_ADDR_EN0, 8'hff);
    wr(IFSW_ADDR_EN1, 8'hff);
    wr(IFSW_ADDR_EN2, 8'hff);
    chk("bresp", resp, IFSW_RESP_OKAY);
    wr(14'h0004, 8'h00);
    chk("wr unmapped", resp, IFSW_RESP_SLVERR);
    rchk("en0", IFSW_ADDR_EN0, IFSW_MASK0);
    rchk("en1", IFSW_ADDR_EN1, IFSW_MASK1);
    rchk("en2", IFSW_ADDR_EN2, IFSW_MASK2);
    u_cpu.rd(14'h0004, rv, resp);
    chk("unmapped", resp, IFSW_RESP_SLVERR);
    wr(IFSW_ADDR_EN0, 8'h00);
    wr(IFSW_ADDR_EN1, 8'h00);
    wr(IFSW_ADDR_EN2, 8'h00);
  endtask : t_regs

  // all events at once with every enable clear, then flag1 and flag2 cleared by writes
  task t_flags();
    pulse(13'h07ff);
    settle(4);
    rchk("flag0 set", IFSW_ADDR_FLAG0, 8'h21);
    rchk("flag1 set", IFSW_ADDR_FLAG1, 8'he7);
    rchk("flag2 set", IFSW_ADDR_FLAG2, 8'he0);
    wr(IFSW_ADDR_FLAG1, 8'h00);
    wr(IFSW_ADDR_FLAG2, 8'h00);
    rchk("flag1 clr", IFSW_ADDR_FLAG1, 8'h00);
    rchk("flag2 clr", IFSW_ADDR_FLAG2, 8'h00);
  endtask : t_flags

  // serial buffer bits follow the buffers, writes cannot clear them
  task t_mirror();
    @(posedge clk);
    rx_ne <= 1'b1;
    tx_emp <= 1'b1;
    wr(IFSW_ADDR_FLAG1, 8'h00);
    rchk("rx tx high", IFSW_ADDR_FLAG1, 8'h18);
    @(posedge clk);
    rx_ne <= 1'b0;
    rchk("rx empty", IFSW_ADDR_FLAG1, 8'h08);
    @(posedge clk);
    tx_emp <= 1'b0;
    rchk("tx loaded", IFSW_ADDR_FLAG1, 8'h00);
  endtask : t_mirror

  task t_irq();
    wr(IFSW_ADDR_EN1, 8'h01);
    pulse(13'h0004);
    settle(3);
    chk("irq no master", periph_irq, 1'b0);
    chk("pend no master", irq_pending, 1'b0);
    wr(IFSW_ADDR_CTRL, 8'h02);
    settle(3);
    chk("irq", periph_irq, 1'b1);
    chk("pending", irq_pending, 1'b1);
    wr(IFSW_ADDR_FLAG1, 8'h00);
    settle(3);
    chk("irq gone", periph_irq, 1'b0);
  endtask : t_irq

  // enabled flag pending with global enable clear: sleep does nothing
  task t_noop();
    pulse(13'h0004);
    settle(3);
    pulse(13'h0800);
    settle(4);
    chk("noop pd", powerdown_status_n, 1'b1);
    chk("noop clk", cpu_clk_en, 1'b1);
    chk("noop wdt", n_clr, 0);
    wr(IFSW_ADDR_FLAG1, 8'h00);
  endtask : t_noop

  task t_sleep();
    @(posedge clk);
    force_on <= 3'b001;
    pulse(13'h0800);
    settle(3);
    chk("pd", powerdown_status_n, 1'b0);
    chk("to", timeout_status_n, 1'b1);
    chk("clk off", cpu_clk_en, 1'b0);
    chk("osc", osc_keep_on, 1'b1);
    chk("hold", port_hold, 8'hf0);
    chk("abort", n_abort, 1);
    chk("wdt entry", n_clr, 1);
    chk("wdt run", wdt_run, 1'b1);
    rchk("stat", IFSW_ADDR_STAT, 32'h0000_0006);
    pulse(13'h0004);
    settle(8);
    chk("clk on", cpu_clk_en, 1'b1);
    chk("resume", n_res, 1);
    chk("no vector", n_vec, 0);
    chk("wdt wake", n_clr, 2);
    wr(IFSW_ADDR_FLAG1, 8'h00);
  endtask : t_sleep

  // watchdog wake, then interrupt wake with global enable set
  task t_wdt();
    @(posedge clk);
    rc_clk <= 1'b1;
    wdt_slp <= 1'b0;
    pulse(13'h0800);
    settle(3);
    chk("rc no abort", n_abort, 1);
    chk("wdt stopped", wdt_run, 1'b0);
    pulse(13'h1000);
    settle(8);
    chk("wdt to", timeout_status_n, 1'b0);
    chk("wdt clk", cpu_clk_en, 1'b1);
    chk("wdt clr", n_clr, 4);
    wr(IFSW_ADDR_CTRL, 8'h03);
    pulse(13'h0800);
    settle(3);
    pulse(13'h0004);
    settle(8);
    chk("vector", n_vec, 1);
    chk("resume2", n_res, 3);
  endtask : t_wdt

  // reset, then every scenario in turn
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_flags();
    t_mirror();
    t_irq();
    t_noop();
    t_sleep();
    t_wdt();
    finish_test();
  end
endmodule : tb
